// [bstu_pkg.sv]
// constants, field layouts and carrier types for the branch-on-sign and trap unit
// assumes a 32-bit core with byte addresses and a register file read ahead of issue
package bstu_pkg;

  localparam logic [5:0]  MAJOR_GROUP_I    = 6'h10;
  localparam logic [4:0]  SUB_NEGATIVE     = 5'h00;
  localparam logic [4:0]  SUB_NEGATIVE_LNK = 5'h01;
  // opcode-map assignments for the not-equal branch and the breakpoint
  localparam logic [5:0]  MAJOR_NOT_EQUAL  = 6'h2D;
  localparam logic [5:0]  MAJOR_TRAP_GRP   = 6'h00;
  localparam logic [5:0]  FUNC_BREAKPOINT  = 6'h07;
  localparam logic [4:0]  LINK_REG         = 5'h1F;
  localparam logic [31:0] INSN_BYTES       = 32'h0000_0004;
  localparam logic [31:0] LINK_BYTES       = 32'h0000_0008;
  localparam int          OFFSET_BITS      = 17;
  localparam int          SIGN_BIT         = 31;

  typedef struct packed {
    logic [5:0]  major;
    logic [4:0]  sub;
    logic [4:0]  reg_a;
    logic [15:0] offset;
  } bstu_instr_t;

  typedef struct packed {
    logic        valid;
    bstu_instr_t instr;
    logic [31:0] pc;
    logic [31:0] reg_a_val;
    logic [31:0] reg_b_val;
  } bstu_issue_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  addr;
    logic [31:0] data;
  } bstu_link_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SLOT
  } bstu_state_t;

endpackage : bstu_pkg

// [bstu_target_calc.sv]
// target and link address arithmetic for one branch
// assumes the branch and its delay slot are both 32-bit words
`timescale 1ns/100ps
module bstu_target_calc
  import bstu_pkg::*;
(
  input  wire logic [31:0] pc_in,
  input  wire logic [15:0] offset_in,
  output logic      [31:0] target_out,
  output logic      [31:0] link_out
);

  logic [31:0] slot_addr;
  logic [31:0] offset_ext;

  assign slot_addr  = pc_in + INSN_BYTES;
  assign offset_ext = {{15{offset_in[15]}}, offset_in, 1'b0};
  assign target_out = slot_addr + offset_ext;
  assign link_out   = pc_in + LINK_BYTES;

endmodule : bstu_target_calc

// [bstu_unit.sv]
// branch-on-sign, not-equal branch and breakpoint control for the fetch/PC logic
// assumes issue, slot_done and slot_exc come from logic on mclk_in; only reset is synchronised
`timescale 1ns/100ps
module bstu_unit (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  input  wire bstu_pkg::bstu_issue_t issue_in,
  input  wire logic                 slot_done_in,
  input  wire logic                 slot_exc_in,
  output logic                      redirect_out,
  output logic [31:0]               target_out,
  output bstu_pkg::bstu_link_t      link_out,
  output logic                      brk_exc_out,
  output logic                      restart_out,
  output logic [31:0]               restart_pc_out,
  output logic                      busy_out
);
  import bstu_pkg::*;

  logic [1:0]  rst_sync;
  logic        rst_n;
  bstu_state_t state;
  bstu_state_t next_state;
  logic        pend_taken;
  logic [31:0] pend_target;
  logic [31:0] pend_pc;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  wire accept     = issue_in.valid && (state == ST_IDLE);
  wire in_group   = issue_in.instr.major == MAJOR_GROUP_I;
  wire is_neg     = accept && in_group && (issue_in.instr.sub == SUB_NEGATIVE);
  wire is_neg_lnk = accept && in_group && (issue_in.instr.sub == SUB_NEGATIVE_LNK);
  wire is_ne      = accept && (issue_in.instr.major == MAJOR_NOT_EQUAL);
  wire is_brk     = accept && (issue_in.instr.major == MAJOR_TRAP_GRP) &&
                    (issue_in.instr.offset[5:0] == FUNC_BREAKPOINT);
  wire is_branch  = is_neg || is_neg_lnk || is_ne;
  wire sign_set   = issue_in.reg_a_val[SIGN_BIT];
  wire regs_diff  = issue_in.reg_a_val != issue_in.reg_b_val;
  wire cond       = ((is_neg || is_neg_lnk) && sign_set) || (is_ne && regs_diff);
  wire slot_end   = (state == ST_SLOT) && (slot_done_in || slot_exc_in);

  logic [31:0] calc_target;
  logic [31:0] calc_link;

  bstu_target_calc u_calc (
    .pc_in      (issue_in.pc),
    .offset_in  (issue_in.instr.offset),
    .target_out (calc_target),
    .link_out   (calc_link)
  );

  // issue is ignored while a delay slot is pending; control flow there is not legal anyway
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (is_branch) begin
          next_state = ST_SLOT;
        end
      end
      ST_SLOT: begin
        if (slot_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      pend_taken  <= 1'b0;
      pend_target <= 32'h0000_0000;
      pend_pc     <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (is_branch) begin
        pend_taken  <= cond;
        pend_target <= calc_target;
        pend_pc     <= issue_in.pc;
      end
    end
  end

  // redirect only once the delay slot has completed without an exception
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      redirect_out   <= 1'b0;
      target_out     <= 32'h0000_0000;
      restart_out    <= 1'b0;
      restart_pc_out <= 32'h0000_0000;
    end else begin
      redirect_out   <= (state == ST_SLOT) && slot_done_in && !slot_exc_in && pend_taken;
      target_out     <= pend_target;
      restart_out    <= (state == ST_SLOT) && slot_exc_in;
      restart_pc_out <= pend_pc;
    end
  end

  // link write is unconditional on the branch outcome
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      link_out    <= '0;
      brk_exc_out <= 1'b0;
      busy_out    <= 1'b0;
    end else begin
      link_out.we   <= is_neg_lnk;
      link_out.addr <= LINK_REG;
      link_out.data <= calc_link;
      brk_exc_out   <= is_brk;
      busy_out      <= next_state == ST_SLOT;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  wire [31:0] reach = pend_target - pend_pc - INSN_BYTES;

  sequence s_neg_sign;
    (is_neg || is_neg_lnk) && sign_set;
  endsequence
  sequence s_slot_ok;
    (state == ST_SLOT) && slot_done_in && !slot_exc_in && pend_taken;
  endsequence

  property p_neg_taken;
    s_neg_sign |=> (state == ST_SLOT) && pend_taken;
  endproperty
  a_neg_taken: assert property (p_neg_taken) else $error("negative branch not taken");

  property p_neg_not_taken;
    (is_neg || is_neg_lnk) && !sign_set |=> !pend_taken ##1 !redirect_out;
  endproperty
  a_neg_not_taken: assert property (p_neg_not_taken) else $error("positive value taken");

  property p_link_write;
    is_neg_lnk |=> link_out.we && (link_out.addr == LINK_REG) &&
                  (link_out.data == $past(issue_in.pc) + LINK_BYTES);
  endproperty
  a_link_write: assert property (p_link_write) else $error("link write wrong");

  property p_no_link;
    accept && !is_neg_lnk |=> !link_out.we;
  endproperty
  a_no_link: assert property (p_no_link) else $error("spurious link write");

  property p_not_equal;
    is_ne |=> pend_taken == ($past(issue_in.reg_a_val) != $past(issue_in.reg_b_val));
  endproperty
  a_not_equal: assert property (p_not_equal) else $error("not-equal outcome wrong");

  property p_redirect;
    s_slot_ok |=> redirect_out && (target_out == $past(pend_target)) && !busy_out;
  endproperty
  a_redirect: assert property (p_redirect) else $error("redirect missing");

  property p_slot_first;
    redirect_out |-> $past(state == ST_SLOT) && $past(slot_done_in);
  endproperty
  a_slot_first: assert property (p_slot_first) else $error("redirect before slot");

  property p_restart;
    (state == ST_SLOT) && slot_exc_in |=> restart_out && !redirect_out &&
                                        (restart_pc_out == $past(pend_pc));
  endproperty
  a_restart: assert property (p_restart) else $error("restart address wrong");

  property p_breakpoint;
    is_brk |=> brk_exc_out ##1 !brk_exc_out || $past(is_brk);
  endproperty
  a_breakpoint: assert property (p_breakpoint) else $error("breakpoint not raised");

  property p_reach;
    state == ST_SLOT |-> (reach[31:OFFSET_BITS-1] == {(33-OFFSET_BITS){reach[31]}}) && !reach[0];
  endproperty
  a_reach: assert property (p_reach) else $error("target out of reach");

  sequence s_slot_wait;
    (state == ST_SLOT) && !slot_done_in && !slot_exc_in;
  endsequence

  // a pending branch holds off both outcomes until the slot reports back
  property p_slot_wait;
    s_slot_wait |=> busy_out && (state == ST_SLOT) && !redirect_out && !restart_out;
  endproperty
  a_slot_wait: assert property (p_slot_wait) else $error("slot wait broken");

  property p_busy_set;
    is_branch |=> busy_out && (state == ST_SLOT);
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("branch did not wait for slot");

  property p_other_sub;
    accept && in_group && !is_neg && !is_neg_lnk |=> !busy_out && !link_out.we && !brk_exc_out;
  endproperty
  a_other_sub: assert property (p_other_sub) else $error("unknown sub-opcode acted on");

  property p_brk_now;
    is_brk |=> brk_exc_out && !busy_out && !redirect_out;
  endproperty
  a_brk_now: assert property (p_brk_now) else $error("breakpoint delayed");

  property p_redirect_pulse;
    redirect_out |=> !redirect_out;
  endproperty
  a_redirect_pulse: assert property (p_redirect_pulse) else $error("redirect longer than one cycle");

  property p_restart_pulse;
    restart_out |=> !restart_out;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart longer than one cycle");

endmodule : bstu_unit

// [bstu_stream.sv]
// instruction stream model: issues one word, then reports how its delay slot ended
// assumes the unit samples issue and slot pulses on the rising edge of mclk_in
`timescale 1ns/100ps
module bstu_stream
  import bstu_pkg::*;
(
  input  wire logic  mclk_in,
  output bstu_issue_t issue_out,
  output logic        slot_done_out,
  output logic        slot_exc_out
);
  initial begin
    issue_out = '0;
    slot_done_out = 1'b0;
    slot_exc_out = 1'b0;
  end
  // slot is a plain 32-bit word, never control flow
  // a negative gap means no delay slot follows (breakpoint or ignored word)
  task automatic send(input bstu_issue_t w, input int gap, input logic exc);
    @(posedge mclk_in) #1 issue_out = w;
    // payload inverted once released so a stale word is never mistaken for a live one
    @(posedge mclk_in) #1 issue_out = {1'b0, ~w[$bits(w)-2:0]};
    if (gap >= 0) begin
      repeat (gap) begin
        @(posedge mclk_in);
        #1;
      end
      slot_done_out = ~exc;
      slot_exc_out = exc;
      @(posedge mclk_in) #1 slot_done_out = 1'b0;
      slot_exc_out = 1'b0;
    end
  endtask : send
endmodule : bstu_stream

// [tb_top.sv]
// self-checking bench for the branch-on-sign and trap unit
// assumes bstu_stream plays the program and fetch side
`timescale 1ns/100ps
module tb_top;
  import bstu_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  bstu_issue_t issue;
  logic        slot_done, slot_exc, redirect, brk, restart, busy;
  logic [31:0] target, restart_pc;
  bstu_link_t  link, last_lk;
  int          err_count = 0, checks = 0, n_rd = 0, n_lk = 0, n_rs = 0, n_bk = 0, n_by = 0;
  always #2.5 mclk_in = ~mclk_in;
  bstu_stream u_src (.mclk_in(mclk_in), .issue_out(issue), .slot_done_out(slot_done), .slot_exc_out(slot_exc));
  bstu_unit dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .issue_in(issue), .slot_done_in(slot_done),
    .slot_exc_in(slot_exc), .redirect_out(redirect), .target_out(target), .link_out(link),
    .brk_exc_out(brk), .restart_out(restart), .restart_pc_out(restart_pc), .busy_out(busy));
  // pulses are counted so a doubled or missing pulse shows up
  always @(posedge mclk_in) begin
    if (redirect === 1'b1) n_rd++;
    if (restart === 1'b1) n_rs++;
    if (brk === 1'b1) n_bk++;
    if (busy === 1'b1) n_by++;
    if (link.we === 1'b1) begin
      n_lk++;
      last_lk = link;
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic do_br(input logic [5:0] mj, input logic [4:0] sb, input logic [15:0] off, input logic [31:0] a,
    input logic [31:0] b, input logic [31:0] pc, input int gap, input logic exc, input int rd, lk, rs);
    bstu_issue_t w;
    int r0, l0, s0, y0;
    w = '{1'b1, '{mj, sb, 5'h03, off}, pc, a, b};
    r0 = n_rd;
    l0 = n_lk;
    s0 = n_rs;
    y0 = n_by;
    u_src.send(w, gap, exc);
    for (int i = 0; i < 10 && busy !== 1'b0; i++) @(posedge mclk_in);
    if (busy !== 1'b0) begin
      chk("busy", busy, 32'h0);
      complete_run();
    end
    repeat (2) @(posedge mclk_in);
    #1;
    chk("redirects", n_rd - r0, rd);
    chk("links", n_lk - l0, lk);
    chk("restarts", n_rs - s0, rs);
    chk("busy cycles", n_by - y0, (gap < 0) ? 0 : gap + 1);
    if (rd != 0) chk("target", target, pc + 32'h4 + {{15{off[15]}}, off, 1'b0});
    if (lk != 0) chk("link data", last_lk.data, pc + 32'h8);
    if (lk != 0) chk("link reg", last_lk.addr, LINK_REG);
    if (rs != 0) chk("restart pc", restart_pc, pc);
  endtask : do_br
  task automatic t_neg;
    do_br(MAJOR_GROUP_I, SUB_NEGATIVE, 16'h8000, 32'h8000_0000, 0, 32'h0002_0000, 0, 0, 1, 0, 0);
    do_br(MAJOR_GROUP_I, SUB_NEGATIVE, 16'h0010, 32'h7FFF_FFFF, 0, 32'h0000_1000, 2, 0, 0, 0, 0);
    $display("test negative branch done");
  endtask : t_neg
  task automatic t_link;
    // tested register is never 31 here
    do_br(MAJOR_GROUP_I, SUB_NEGATIVE_LNK, 16'h0040, 32'h0000_0001, 0, 32'h0000_4000, 1, 0, 0, 1, 0);
    do_br(MAJOR_GROUP_I, SUB_NEGATIVE_LNK, 16'h7FFF, 32'hFFFF_FFFF, 0, 32'h0010_0000, 3, 0, 1, 1, 0);
    $display("test link branch done");
  endtask : t_link
  task automatic t_bne;
    do_br(MAJOR_NOT_EQUAL, 5'h00, 16'h0020, 32'h1234_5678, 32'h1234_5678, 32'h0000_2000, 0, 0, 0, 0, 0);
    do_br(MAJOR_NOT_EQUAL, 5'h00, 16'hFFF0, 32'h8000_0001, 32'h8000_0000, 32'h0000_2000, 1, 0, 1, 0, 0);
    $display("test not-equal branch done");
  endtask : t_bne
  task automatic t_exc;
    do_br(MAJOR_GROUP_I, SUB_NEGATIVE_LNK, 16'h0100, 32'h8000_0000, 0, 32'h0000_8000, 1, 1, 0, 1, 1);
    $display("test slot exception done");
  endtask : t_exc
  task automatic t_brk;
    int b0;
    b0 = n_bk;
    do_br(MAJOR_TRAP_GRP, 5'h00, {10'h2A5, FUNC_BREAKPOINT}, 0, 0, 32'h0000_3000, -1, 0, 0, 0, 0);
    chk("breakpoints", n_bk - b0, 1);
    do_br(MAJOR_GROUP_I, 5'h02, 16'h0004, 32'h8000_0000, 0, 32'h0000_3000, -1, 0, 0, 0, 0);
    chk("breakpoints", n_bk - b0, 1);
    $display("test breakpoint done");
  endtask : t_brk
  initial begin
    repeat (8) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    t_neg();
    t_link();
    t_bne();
    t_exc();
    t_brk();
    complete_run();
  end
endmodule : tb_top
